// file: board_status_and_image_select_test.sv
`timescale 1ns/1ps
module board_status_and_image_select_test;
   import bsi_pkg::*;
   // stimulus and observed signals
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic clk_en = 1'b1;
   logic image_select_upper = 1'b0;
   logic image_select_lower = 1'b1;
   logic reload_button = 1'b0;
   logic buffer_clear_button = 1'b0;
   logic host_link_busy = 1'b0;
   logic conv_en = 1'b0;
   logic converter_clock;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rsp;
   logic [31:0] rdata, rd;
   bsi_image_t config_image;
   logic par_mode, ser_mode, cm_rst, buffer_clear;
   logic conf_led, rdy_led, ref_led, conv_led, host_led;
   logic [15:0] baud_divisor;
   int errors = 0;
   int n_tests = 0;
   int bc_n = 0;
   bsi_image_t img_tab [4] = '{IMG_SERIAL, IMG_PARALLEL, IMG_FOUR, IMG_THREE};

   // short interval so a reference heartbeat slot lasts about ten aclk cycles
   bsi_top #(.HB_INTERVAL(25'h40)) DUT (
      .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
      .image_select_upper(image_select_upper), .image_select_lower(image_select_lower),
      .reload_button(reload_button), .buffer_clear_button(buffer_clear_button),
      .converter_clock(converter_clock), .host_link_busy(host_link_busy),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .config_image(config_image), .parallel_ddr_mode(par_mode),
      .serial_mode(ser_mode), .clock_manager_reset(cm_rst), .buffer_clear(buffer_clear),
      .baud_divisor(baud_divisor), .configured_indicator(conf_led),
      .ready_indicator(rdy_led), .reference_heartbeat_indicator(ref_led),
      .converter_clock_indicator(conv_led), .host_activity_indicator(host_led)
   );

   // far side: converter clock
   bsi_conv_model conv (
      .en(conv_en),
      .conv_clk(converter_clock)
   );

   // 40 MHz clock
   always #12.5 aclk = ~aclk;

   // count clear pulses at the falling edge, where they are settled
   always @(negedge aclk) begin
      if (buffer_clear === 1'b1) bc_n++;
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task stop_test();
      $display("comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // write: address and data offered together, bready held until the answer
   task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!(bvalid && !awvalid && !wvalid) && n < 100);
      r = bresp;
      bready <= 1'b0;
      if (n >= 100) errors++;
   endtask

   task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (!(rvalid && !arvalid) && n < 100);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n >= 100) errors++;
   endtask

   // hold a button well past the debounce span
   task push(input bit clr);
      @(posedge aclk);
      if (clr) buffer_clear_button <= 1'b1;
      else reload_button <= 1'b1;
      repeat (8) @(posedge aclk);
      buffer_clear_button <= 1'b0;
      reload_button <= 1'b0;
   endtask

   // power-up: load then clock manager reset, then ready
   task t_power();
      int n, m;
      n = 0;
      m = 0;
      while (conf_led !== 1'b1 && n < 200) begin
         @(negedge aclk);
         n++;
      end
      check(n - LOAD_CYC <= 1 && n >= LOAD_CYC, 1);
      check(cm_rst, 1'b1);
      check(rdy_led, 1'b0);
      while (rdy_led !== 1'b1 && m < 50) begin
         @(negedge aclk);
         m++;
      end
      check(m, CMRST_CYC);
      check(cm_rst, 1'b0);
      check(config_image, IMG_PARALLEL);
      check(conv_led, 1'b0);
      axr(ADDR_BAUD, rd, rsp);
      check(rd, 32'(BAUD_RST));
      $display("power-up test done");
   endtask

   // every select code, last one reloaded through the control register
   task t_images();
      int n;
      for (int i = 0; i < 4; i++) begin
         n = 0;
         axw(ADDR_BAUD, 32'h100 + i, rsp);
         @(posedge aclk);
         image_select_upper <= i[1];
         image_select_lower <= i[0];
         if (i == 3) axw(ADDR_CONTROL, 32'h1, rsp);
         else push(1'b0);
         @(negedge aclk);
         check(conf_led, 1'b0);
         while (rdy_led !== 1'b1 && n < 300) begin
            @(negedge aclk);
            n++;
         end
         check(config_image, img_tab[i]);
         check(par_mode, img_tab[i] == IMG_PARALLEL);
         check(ser_mode, img_tab[i] == IMG_SERIAL);
         @(posedge aclk);
         image_select_upper <= ~i[1];
         image_select_lower <= ~i[0];
         repeat (20) @(posedge aclk);
         check(config_image, img_tab[i]);
         axr(ADDR_STATUS, rd, rsp);
         check(rd[5:0], {~i[1], ~i[0], 2'(img_tab[i]), 2'b11});
         axr(ADDR_BAUD, rd, rsp);
         check(rd, 32'(BAUD_RST));
      end
      $display("image select test done");
   endtask

   // buffer clear by button and by register keeps settings
   task t_bufclr();
      axw(ADDR_BAUD, 32'h77, rsp);
      bc_n = 0;
      push(1'b1);
      repeat (12) @(posedge aclk);
      check(bc_n, 1);
      axw(ADDR_CONTROL, 32'h2, rsp);
      repeat (3) @(posedge aclk);
      check(bc_n, 2);
      axr(ADDR_BAUD, rd, rsp);
      check(rd, 32'h77);
      check(baud_divisor, 32'h77);
      check({conf_led, rdy_led}, 2'b11);
      axw(8'h10, 32'h5, rsp);
      check(rsp, RESP_SLVERR);
      axr(8'h10, rd, rsp);
      check(rd, 32'h0);
      check(rsp, RESP_SLVERR);
      axw(ADDR_STATUS, 32'h0, rsp);
      check(rsp, RESP_OKAY);
      $display("buffer clear test done");
   endtask

   task t_host();
      @(posedge aclk);
      host_link_busy <= 1'b1;
      repeat (3) @(negedge aclk);
      check(host_led, 1'b1);
      @(posedge aclk);
      host_link_busy <= 1'b0;
      repeat (3) @(negedge aclk);
      check(host_led, 1'b0);
      // a low clock enable freezes the indicator even while the host is busy
      @(posedge aclk);
      clk_en <= 1'b0;
      host_link_busy <= 1'b1;
      repeat (3) @(negedge aclk);
      check(host_led, 1'b0);
      @(posedge aclk);
      clk_en <= 1'b1;
      host_link_busy <= 1'b0;
      repeat (3) @(negedge aclk);
      $display("host activity test done");
   endtask

   // one converter pattern lasts 512 ticks, a reference one about 82 aclk cycles: two of eight slots lit
   task t_beats();
      int on;
      on = 0;
      repeat (819) @(negedge aclk) if (ref_led === 1'b1) on++;
      check(on >= 195 && on <= 215, 1);
      @(posedge aclk);
      conv_en <= 1'b1;
      repeat (200) @(posedge aclk);
      on = 0;
      repeat (2089) @(negedge aclk) if (conv_led === 1'b1) on++;
      check(on >= 480 && on <= 565, 1);
      @(posedge aclk);
      conv_en <= 1'b0;
      repeat (100) @(posedge aclk);
      on = 0;
      repeat (200) @(negedge aclk) if (conv_led === 1'b1) on++;
      check(on, 0);
      $display("heartbeat test done");
   endtask

   // main sequence
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_power();
      t_images();
      t_bufclr();
      t_host();
      t_beats();
      stop_test();
   end

   // watchdog, well beyond the expected run of some 4000 cycles
   initial begin
      #500000;
      errors++;
      stop_test();
   end
endmodule

// file: bsi_conv_model.sv
`timescale 1ns/1ps
// converter board clock as seen by the block, one level per lvds pair
module bsi_conv_model #(
   parameter int HALF_NS = 51
) (
   // control from the bench
   input wire logic en,
   // clock toward the block
   output logic conv_clk
);
   // stands still low while the board is unpowered; odd half period keeps phase apart from aclk
   initial begin
      conv_clk = 1'b0;
      forever begin
         #(HALF_NS);
         conv_clk = en ? ~conv_clk : 1'b0;
      end
   end
endmodule

// file: bsi_hb_if.sv
`timescale 1ns/1ps
interface bsi_hb_if;
   logic tick;
   logic [4:0] step;
   logic clear;
   logic led;
   modport core(input tick, input step, input clear, output led);
   modport ctl(output tick, output step, output clear, input led);
endinterface

// file: bsi_heartbeat.sv
`timescale 1ns/1ps
module bsi_heartbeat #(
   parameter logic [24:0] INTERVAL = 25'h17d7840,
   parameter logic [7:0] TIMEOUT = 8'h40
) (
   // clock and control
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // tick source and indicator
   bsi_hb_if.core hb
);
   import bsi_pkg::*;

   localparam logic [27:0] INT4 = {1'b0, INTERVAL, 2'b00};

   typedef struct packed {
      logic [26:0] cnt;
      logic [2:0] phase;
      logic [7:0] idle;
      logic led;
   } bsi_hb_state_t;

   bsi_hb_state_t s_reg;
   bsi_hb_state_t s_next;
   logic [27:0] sum;

   assign sum = {1'b0, s_reg.cnt} + {23'h0, hb.step};

   // free-running interval divider stepping an eight-slot pattern
   always_comb begin
      s_next = s_reg;
      if (hb.clear) begin
         s_next = '0;
         // start as if timed out, so a missing clock never lights slot 0 after a load
         s_next.idle = TIMEOUT;
      end else begin
         if (hb.tick) begin
            s_next.idle = 8'h00;
            if (sum >= INT4) begin
               s_next.cnt = 27'(sum - INT4);
               s_next.phase = s_reg.phase + 3'h1;
            end else begin
               s_next.cnt = sum[26:0];
            end
         end else if (s_reg.idle != TIMEOUT) begin
            s_next.idle = s_reg.idle + 8'h01;
         end
         // slots 0 and 2 lit, the other six dark; no ticks means dark
         s_next.led = (s_next.idle != TIMEOUT) &&
                      (s_next.phase == HB_ON_A || s_next.phase == HB_ON_B);
      end
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg <= '0;
      end else if (clk_en) begin
         s_reg <= s_next;
      end
   end

   assign hb.led = s_reg.led;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_HB_PATTERN: assert property (hb.led |-> s_reg.phase == HB_ON_A ||
      s_reg.phase == HB_ON_B) else $error("indicator lit outside an on slot");
   AST_HB_WRAP: assert property (clk_en && !hb.clear && hb.tick && sum >= INT4
      |=> s_reg.phase == $past(s_reg.phase) + 3'h1 && {1'b0, s_reg.cnt} < INT4)
      else $error("interval terminal count did not advance the pattern");
   AST_HB_DARK: assert property (s_reg.idle == TIMEOUT |-> !hb.led)
      else $error("indicator lit with no clock present");
   COV_HB_LIT: cover property ($rose(hb.led));

endmodule

// file: bsi_pkg.sv
//Contract
//- reload button or power-up loads selected image
//- select decode 00 serial,01 parallel,10 four,11 three
//- select change acts only at next load
//- loading image clears every register and data (code resets baud and pending reload only, and does not pulse buffer_clear)
//- buffer clear empties capture buffer, keeps registers
//- parallel image for DDR, serial for serialized
//- decode spans four images, two installed now
//- configured indicator lights once loading completes
//- clock manager reset precedes ready indicator
//- reference time base is 250 MHz multiplied clock
//- heartbeat on, off, on, then five off
//- converter indicator same pattern, dark without clock
//- host indicator lit while host accesses device
package bsi_pkg;

   // clock and derived timing
   localparam int CLK_MHZ = 40;
   localparam int CLK_PERIOD_NS = 25;
   localparam int LOAD_TIME_NS = 2000;
   localparam int LOAD_CYC = (LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] LOAD_LAST = 8'(LOAD_CYC - 1);
   localparam int CMRST_TIME_NS = 100;
   localparam int CMRST_CYC = (CMRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] CMRST_LAST = 8'(CMRST_CYC - 1);
   localparam int DEB_TIME_NS = 100;
   localparam int DEB_CYC = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] DEB_LAST = 3'(DEB_CYC - 1);

   // heartbeat: counts in quarter reference cycles
   localparam int REF_MHZ = 250;
   localparam logic [4:0] REF_QSTEP = 5'(REF_MHZ * 4 / CLK_MHZ);
   localparam logic [4:0] CONV_QSTEP = 5'h04;
   localparam logic [24:0] HB_INTERVAL_DEF = 25'h17d7840;
   localparam logic [7:0] CONV_TIMEOUT = 8'h40;
   localparam logic [2:0] HB_ON_A = 3'h0;
   localparam logic [2:0] HB_ON_B = 3'h2;

   // register map, byte addresses
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_BAUD = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam int CTRL_RELOAD_BIT = 0;
   localparam int CTRL_BUFCLR_BIT = 1;
   localparam logic [15:0] BAUD_RST = 16'h0015;
   localparam int STAT_CONFIGURED = 0;
   localparam int STAT_READY = 1;
   localparam int STAT_IMAGE_LSB = 2;
   localparam int STAT_SEL_LSB = 4;
   localparam int STAT_REF_LED = 6;
   localparam int STAT_CONV_LED = 7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // four image slots in the configuration memory
   typedef enum logic [1:0] {
      IMG_PARALLEL = 2'h0,
      IMG_SERIAL = 2'h1,
      IMG_THREE = 2'h2,
      IMG_FOUR = 2'h3
   } bsi_image_t;

   // configuration sequence, gray along load, clock reset, run
   typedef enum logic [1:0] {
      ST_LOAD = 2'h0,
      ST_CLKRST = 2'h1,
      ST_RUN = 2'h3
   } bsi_seq_t;

   // upper select listed first
   function automatic bsi_image_t bsi_decode(input logic upper, input logic lower);
      bsi_image_t img;
      img = IMG_SERIAL;
      unique case ({upper, lower})
         2'b00: img = IMG_SERIAL;
         2'b01: img = IMG_PARALLEL;
         2'b10: img = IMG_FOUR;
         2'b11: img = IMG_THREE;
      endcase
      return img;
   endfunction

endpackage

// file: bsi_press.sv
`timescale 1ns/1ps
module bsi_press (
   // clock and control
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // button level in, press pulse out
   input wire logic button,
   output logic press
);
   import bsi_pkg::*;

   typedef struct packed {
      logic level;
      logic [2:0] cnt;
      logic press;
   } bsi_press_state_t;

   bsi_press_state_t s_reg;
   bsi_press_state_t s_next;

   // filter contact bounce: a level must hold for the debounce time
   always_comb begin
      s_next = s_reg;
      s_next.press = 1'b0;
      if (button != s_reg.level) begin
         if (s_reg.cnt == DEB_LAST) begin
            s_next.level = button;
            s_next.cnt = 3'h0;
            s_next.press = button;
         end else begin
            s_next.cnt = s_reg.cnt + 3'h1;
         end
      end else begin
         s_next.cnt = 3'h0;
      end
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg <= '0;
      end else if (clk_en) begin
         s_reg <= s_next;
      end
   end

   assign press = s_reg.press;

   AST_PRESS_PULSE: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && press |=> !press) else $error("press lasted more than one cycle");

endmodule

// file: bsi_top.sv
`timescale 1ns/1ps
module bsi_top #(
   parameter logic [24:0] HB_INTERVAL = bsi_pkg::HB_INTERVAL_DEF
) (
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // board inputs
   input wire logic image_select_upper,
   input wire logic image_select_lower,
   input wire logic reload_button,
   input wire logic buffer_clear_button,
   input wire logic converter_clock,
   input wire logic host_link_busy,
   // axi4-lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // configuration status
   output bsi_pkg::bsi_image_t config_image,
   output logic parallel_ddr_mode,
   output logic serial_mode,
   output logic clock_manager_reset,
   output logic buffer_clear,
   output logic [15:0] baud_divisor,
   // indicators
   output logic configured_indicator,
   output logic ready_indicator,
   output logic reference_heartbeat_indicator,
   output logic converter_clock_indicator,
   output logic host_activity_indicator
);
   import bsi_pkg::*;

   typedef struct packed {
      bsi_seq_t st;
      logic [7:0] seq_cnt;
      bsi_image_t image;
      logic [15:0] baud;
      logic reload_req;
      logic bufclr;
      logic conv_meta;
      logic conv_q;
      logic conv_prev;
      logic host_led;
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } bsi_top_state_t;

   bsi_top_state_t s_reg;
   bsi_top_state_t s_next;
   logic reload_press;
   logic bufclr_press;
   logic wr_fire;
   logic [31:0] status_word;

   bsi_hb_if ref_hb();
   bsi_hb_if conv_hb();

   // debounced button presses
   bsi_press u_reload_press (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_en(clk_en),
      .button(reload_button),
      .press(reload_press)
   );

   bsi_press u_bufclr_press (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_en(clk_en),
      .button(buffer_clear_button),
      .press(bufclr_press)
   );

   // reference time base: 250 MHz expressed as quarter steps per aclk cycle
   assign ref_hb.tick = 1'b1;
   assign ref_hb.step = REF_QSTEP;
   assign ref_hb.clear = (s_reg.st == ST_LOAD);

   // converter clock edges seen at aclk; only slow clocks resolve
   assign conv_hb.tick = s_reg.conv_q & ~s_reg.conv_prev;
   assign conv_hb.step = CONV_QSTEP;
   assign conv_hb.clear = (s_reg.st == ST_LOAD);

   // both dividers share one terminal count so rates compare directly
   bsi_heartbeat #(.INTERVAL(HB_INTERVAL), .TIMEOUT(8'hff)) u_ref_hb (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_en(clk_en),
      .hb(ref_hb)
   );

   bsi_heartbeat #(.INTERVAL(HB_INTERVAL), .TIMEOUT(CONV_TIMEOUT)) u_conv_hb (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_en(clk_en),
      .hb(conv_hb)
   );

   // status word assembled from live state
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[STAT_CONFIGURED] = configured_indicator;
      status_word[STAT_READY] = ready_indicator;
      status_word[STAT_IMAGE_LSB +: 2] = s_reg.image;
      status_word[STAT_SEL_LSB +: 2] = {image_select_upper, image_select_lower};
      status_word[STAT_REF_LED] = ref_hb.led;
      status_word[STAT_CONV_LED] = conv_hb.led;
   end

   assign wr_fire = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;

   // sequence, register file and bus slave
   always_comb begin
      s_next = s_reg;
      s_next.bufclr = 1'b0;
      s_next.conv_meta = converter_clock; // foreign clock: only conv_q may read this stage
      s_next.conv_q = s_reg.conv_meta;
      s_next.conv_prev = s_reg.conv_q;
      s_next.host_led = host_link_busy | s_reg.aw_held | s_reg.w_held |
                        s_reg.bvalid | s_reg.rvalid;
      unique case (s_reg.st)
         ST_LOAD: begin
            // selection sampled only while loading
            s_next.image = bsi_decode(image_select_upper, image_select_lower);
            if (s_reg.seq_cnt == LOAD_LAST) begin
               s_next.st = ST_CLKRST;
               s_next.seq_cnt = 8'h00;
            end else begin
               s_next.seq_cnt = s_reg.seq_cnt + 8'h01;
            end
         end
         ST_CLKRST: begin
            if (s_reg.seq_cnt == CMRST_LAST) begin
               s_next.st = ST_RUN;
               s_next.seq_cnt = 8'h00;
            end else begin
               s_next.seq_cnt = s_reg.seq_cnt + 8'h01;
            end
         end
         ST_RUN: begin
            if (bufclr_press) begin
               s_next.bufclr = 1'b1;
            end
         end
         default: begin
            s_next.st = ST_LOAD;
            s_next.seq_cnt = 8'h00;
         end
      endcase
      // address and data taken in either order
      if (s_axi_awvalid && !s_reg.aw_held) begin
         s_next.aw_held = 1'b1;
         s_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_reg.w_held) begin
         s_next.w_held = 1'b1;
         s_next.w_data = s_axi_wdata;
         s_next.w_strb = s_axi_wstrb;
      end
      if (s_reg.bvalid && s_axi_bready) begin
         s_next.bvalid = 1'b0;
      end
      if (wr_fire) begin
         s_next.aw_held = 1'b0;
         s_next.w_held = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = RESP_OKAY;
         unique case (s_reg.aw_addr)
            ADDR_CONTROL: begin
               if (s_reg.w_strb[0] && s_reg.w_data[CTRL_RELOAD_BIT]) begin
                  s_next.reload_req = 1'b1;
               end
               if (s_reg.w_strb[0] && s_reg.w_data[CTRL_BUFCLR_BIT] &&
                   s_reg.st == ST_RUN) begin
                  s_next.bufclr = 1'b1;
               end
            end
            ADDR_BAUD: begin
               if (s_reg.w_strb[0]) begin
                  s_next.baud[7:0] = s_reg.w_data[7:0];
               end
               if (s_reg.w_strb[1]) begin
                  s_next.baud[15:8] = s_reg.w_data[15:8];
               end
            end
            ADDR_STATUS: begin
               s_next.bresp = RESP_OKAY;
            end
            default: begin
               s_next.bresp = RESP_SLVERR;
            end
         endcase
      end
      // reads answer one cycle after the address is taken
      if (s_reg.rvalid && s_axi_rready) begin
         s_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !s_reg.rvalid) begin
         s_next.rvalid = 1'b1;
         s_next.rresp = RESP_OKAY;
         unique case (s_axi_araddr)
            ADDR_CONTROL: s_next.rdata = 32'h0000_0000;
            ADDR_BAUD: s_next.rdata = {16'h0000, s_reg.baud};
            ADDR_STATUS: s_next.rdata = status_word;
            default: begin
               s_next.rdata = 32'h0000_0000;
               s_next.rresp = RESP_SLVERR;
            end
         endcase
      end
      // a load wipes software settings as a power cycle would
      if (s_reg.st == ST_LOAD) begin
         s_next.baud = BAUD_RST;
         s_next.reload_req = 1'b0;
      end
      // a press restarts the load from any state, even mid-load; a register reload written mid-load is cleared
      if (reload_press || s_reg.reload_req) begin
         s_next.st = ST_LOAD;
         s_next.seq_cnt = 8'h00;
      end
   end

   // power-up enters the load state, which is the all-zero code
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg <= '0;
      end else if (clk_en) begin
         s_reg <= s_next;
      end
   end

   // outputs from registered state
   assign s_axi_awready = !s_reg.aw_held;
   assign s_axi_wready = !s_reg.w_held;
   assign s_axi_bvalid = s_reg.bvalid;
   assign s_axi_bresp = s_reg.bresp;
   assign s_axi_arready = !s_reg.rvalid;
   assign s_axi_rvalid = s_reg.rvalid;
   assign s_axi_rdata = s_reg.rdata;
   assign s_axi_rresp = s_reg.rresp;
   assign config_image = s_reg.image;
   assign configured_indicator = (s_reg.st != ST_LOAD);
   assign ready_indicator = (s_reg.st == ST_RUN);
   assign clock_manager_reset = (s_reg.st != ST_RUN);
   assign parallel_ddr_mode = configured_indicator && s_reg.image == IMG_PARALLEL;
   assign serial_mode = configured_indicator && s_reg.image == IMG_SERIAL;
   assign buffer_clear = s_reg.bufclr;
   assign baud_divisor = s_reg.baud;
   assign reference_heartbeat_indicator = ref_hb.led;
   assign converter_clock_indicator = conv_hb.led;
   assign host_activity_indicator = s_reg.host_led;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_RELOAD_LOAD: assert property (clk_en && reload_press
      |=> s_reg.st == ST_LOAD && s_reg.seq_cnt == 8'h00)
      else $error("reload press did not restart the load");
   AST_SEL_DECODE: assert property (clk_en && s_reg.st == ST_LOAD
      |=> s_reg.image == bsi_decode($past(image_select_upper), $past(image_select_lower)))
      else $error("image decode mismatch");
   AST_SEL_HOLD: assert property ((s_reg.st != ST_LOAD) ##1 (s_reg.st != ST_LOAD)
      |-> $stable(s_reg.image)) else $error("image changed outside a load");
   AST_LOAD_CLEARS: assert property (clk_en && s_reg.st == ST_LOAD
      |=> s_reg.baud == BAUD_RST && !s_reg.reload_req)
      else $error("load left a register setting");
   AST_BUFCLR_KEEP: assert property (clk_en && bufclr_press && !reload_press &&
      !s_reg.reload_req && !wr_fire && s_reg.st == ST_RUN
      |=> buffer_clear && s_reg.st == ST_RUN && $stable(s_reg.baud))
      else $error("buffer clear disturbed configuration");
   AST_MODE: assert property (parallel_ddr_mode |-> s_reg.image == IMG_PARALLEL &&
      !serial_mode) else $error("mode does not match image");
   AST_CONFIGURED: assert property (clk_en && s_reg.st == ST_LOAD &&
      s_reg.seq_cnt == LOAD_LAST && !reload_press && !s_reg.reload_req
      |=> configured_indicator && clock_manager_reset && !ready_indicator)
      else $error("configured indicator not lit after load");
   AST_READY_AFTER_CMRST: assert property ($rose(ready_indicator)
      |-> $past(clock_manager_reset) && $past(s_reg.st) == ST_CLKRST)
      else $error("ready without clock manager reset");
   AST_HOST: assert property (clk_en && host_link_busy |=> host_activity_indicator)
      else $error("host indicator dark during access");

   COV_RUN: cover property (s_reg.st == ST_CLKRST ##1 s_reg.st == ST_RUN);
   COV_BUFCLR: cover property (buffer_clear);
   COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);

endmodule
